// ==== dps_supervisor.sv ====
// Drive protection supervisor: stall prevention, over-torque, APB regs
`timescale 1ns/10ps
// Function
// - Hold frequency on bus over-voltage while decelerating
// - Hold frequency while accel current over limit
// - One hundred percent equals rated output current
// - Lower frequency when running current exceeds limit
// - Reaccelerate toward command once current drops
// - Mode zero off, 1-2 constant, 3-4 accel
// - Modes 2,4 stop; 1,3 keep running unless a thermal or drive overload trip is set
// - Warn after current above level beyond time
// - Output function 04 drives over-torque output
// - Torque level 10 to 200, default 150
// - Torque time 0.1 to 60.0 s
// - Thermal select 0,1,2; default 2
module dps_supervisor
  import dps_pkg::*;
#(
  parameter int CW = 16,
  parameter int unsigned TICK_CYC = TENTH_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [CW-1:0] I_OUT,
  input wire logic [CW-1:0] I_RATED,
  input wire logic [15:0] V_BUS,
  input wire logic [1:0] PHASE,
  input wire logic [15:0] F_CMD,
  input wire logic [15:0] F_STEP,
  input wire logic THERMAL_OVERLOAD_TRIP,
  input wire logic DRIVE_OVERLOAD_TRIP,
  output logic [15:0] F_OUT,
  output logic FREQ_HOLD,
  output logic FREQ_LOWER,
  output logic OVER_TORQUE_WARNING,
  output logic DRIVE_STOP,
  output logic MFO,
  output logic [1:0] THERMAL_MODE,
  output logic IRQ
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [15:0] ov_lvl_r, acc_lvl_r, run_lvl_r, ot_mode_r;
  logic [15:0] ot_lvl_r, ot_time_r, therm_r, out_fn_r;
  logic [IRQ_W-1:0] irq_st_r, irq_mask_r, irq_ev;
  logic wr, rd;
  logic [15:0] wv;
  dps_phase_e ph;

  assign ph = dps_phase_e'(PHASE);
  assign wr = PSEL && PENABLE && PWRITE;
  // Read data is captured in the setup cycle so it stands at the access edge
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign wv = PWDATA[15:0];
  assign PREADY = 1'b1;

  function automatic logic [15:0] clamp(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    clamp = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= OFF_IRQ_MASK) && (a[1:0] == 2'b00);
  endfunction

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ov_lvl_r <= RST_OV_LVL;
      acc_lvl_r <= RST_ACC_LVL;
      run_lvl_r <= RST_RUN_LVL;
      ot_mode_r <= RST_OT_MODE;
      ot_lvl_r <= RST_OT_LVL;
      ot_time_r <= RST_OT_TIME;
      therm_r <= RST_THERM;
      out_fn_r <= RST_OUT_FN;
      irq_mask_r <= '0;
    end else if (wr) begin
      unique case (PADDR)
        OFF_OV_LVL: ov_lvl_r <= wv;
        OFF_ACC_LVL: acc_lvl_r <= wv;
        OFF_RUN_LVL: run_lvl_r <= wv;
        OFF_OT_MODE: ot_mode_r <= (wv > OT_MODE_MAX) ? ot_mode_r : wv;
        OFF_OT_LVL: ot_lvl_r <= clamp(wv, OT_LVL_MIN, OT_LVL_MAX);
        OFF_OT_TIME: ot_time_r <= clamp(wv, OT_TIME_MIN, OT_TIME_MAX);
        OFF_THERM: therm_r <= (wv > THERM_MAX) ? therm_r : wv;
        OFF_OUT_FN: out_fn_r <= wv;
        OFF_IRQ_MASK: irq_mask_r <= PWDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= 1'b0;
      if (rd) begin
        unique case (PADDR)
          OFF_OV_LVL: PRDATA <= {16'h0000, ov_lvl_r};
          OFF_ACC_LVL: PRDATA <= {16'h0000, acc_lvl_r};
          OFF_RUN_LVL: PRDATA <= {16'h0000, run_lvl_r};
          OFF_OT_MODE: PRDATA <= {16'h0000, ot_mode_r};
          OFF_OT_LVL: PRDATA <= {16'h0000, ot_lvl_r};
          OFF_OT_TIME: PRDATA <= {16'h0000, ot_time_r};
          OFF_THERM: PRDATA <= {16'h0000, therm_r};
          OFF_OUT_FN: PRDATA <= {16'h0000, out_fn_r};
          OFF_STATUS: PRDATA <= {26'h0, DRIVE_STOP, OVER_TORQUE_WARNING,
                                 FREQ_LOWER, FREQ_HOLD, THERMAL_MODE};
          OFF_IRQ_ST: PRDATA <= {{(32-IRQ_W){1'b0}}, irq_st_r};
          OFF_IRQ_MASK: PRDATA <= {{(32-IRQ_W){1'b0}}, irq_mask_r};
          default: PRDATA <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Zero wait states: the word loaded at the setup edge is what the
  // master samples at the completing access edge

  // ------------------------------------------------------------
  // Protection logic
  // ------------------------------------------------------------
  logic [CW-1:0] acc_lim, run_lim, ot_lim;
  logic ov_hold, acc_hold, run_lower, ot_window, ot_expired;
  logic ot_warn_r, stop_r;
  logic [15:0] f_r, f_nxt;

  dps_scale #(.CW(CW)) u_acc (.PCT(acc_lvl_r), .RATED(I_RATED),
    .LIMIT(acc_lim));
  dps_scale #(.CW(CW)) u_run (.PCT(run_lvl_r), .RATED(I_RATED),
    .LIMIT(run_lim));
  dps_scale #(.CW(CW)) u_ot (.PCT(ot_lvl_r), .RATED(I_RATED),
    .LIMIT(ot_lim));

  assign ov_hold = (ph == DPS_DECEL) && (ov_lvl_r != 16'h0000) &&
    (V_BUS > ov_lvl_r);
  assign acc_hold = (ph == DPS_ACCEL) && (acc_lvl_r != 16'h0000) &&
    (I_OUT > acc_lim);
  assign run_lower = (ph != DPS_IDLE) && (ph != DPS_ACCEL) &&
    (run_lvl_r != 16'h0000) && (I_OUT > run_lim) && !ov_hold;

  // Frequency ramp: hold wins over lowering, lowering wins over ramp
  always_comb begin
    f_nxt = f_r;
    if (stop_r || ph == DPS_IDLE)
      f_nxt = 16'h0000;
    else if (ov_hold || acc_hold)
      f_nxt = f_r;
    else if (run_lower)
      f_nxt = (f_r > F_STEP) ? f_r - F_STEP : 16'h0000;
    else if (f_r < F_CMD)
      f_nxt = (F_CMD - f_r > F_STEP) ? f_r + F_STEP : F_CMD;
    else if (f_r > F_CMD)
      f_nxt = (f_r - F_CMD > F_STEP) ? f_r - F_STEP : F_CMD;
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST)
      f_r <= 16'h0000;
    else
      f_r <= f_nxt;
  end

  assign ot_window = ((ot_mode_r == 16'h0001 || ot_mode_r == 16'h0002) &&
    ph == DPS_CONST) || ((ot_mode_r == 16'h0003 ||
    ot_mode_r == 16'h0004) && ph == DPS_ACCEL);

  dps_timer #(.TICK_CYC(TICK_CYC)) u_tmr (.REF_CLK(REF_CLK), .RST(RST),
    .ARM(ot_window && (I_OUT > ot_lim)), .LIMIT(ot_time_r),
    .EXPIRED(ot_expired));

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      ot_warn_r <= 1'b0;
      stop_r <= 1'b0;
    end else begin
      ot_warn_r <= ot_expired;
      if (ot_expired && (ot_mode_r == 16'h0002 || ot_mode_r == 16'h0004))
        stop_r <= 1'b1;
      else if (ot_expired && (THERMAL_OVERLOAD_TRIP || DRIVE_OVERLOAD_TRIP))
        stop_r <= 1'b1;
      else if (F_CMD == 16'h0000)
        stop_r <= 1'b0;
    end
  end

  assign irq_ev = {run_lower, acc_hold, ov_hold, ot_expired && !ot_warn_r};
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST)
      irq_st_r <= '0;
    else if (wr && PADDR == OFF_IRQ_ST)
      irq_st_r <= (irq_st_r & ~PWDATA[IRQ_W-1:0]) | irq_ev;
    else
      irq_st_r <= irq_st_r | irq_ev;
  end

  assign F_OUT = f_r;
  assign FREQ_HOLD = ov_hold || acc_hold;
  assign FREQ_LOWER = run_lower;
  assign OVER_TORQUE_WARNING = ot_warn_r;
  assign DRIVE_STOP = stop_r;
  assign MFO = (out_fn_r == FN_OVER_TORQUE) && ot_warn_r;
  assign THERMAL_MODE = therm_r[1:0];
  assign IRQ = |(irq_st_r & irq_mask_r);

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  a_ov_hold_freq: assert property (@(posedge REF_CLK) disable iff (RST)
    ov_hold && !stop_r |=> f_r == $past(f_r))
    else $error("frequency moved during over-voltage hold");
  a_acc_hold_freq: assert property (@(posedge REF_CLK) disable iff (RST)
    acc_hold && !stop_r && ph == DPS_ACCEL |=> f_r == $past(f_r))
    else $error("frequency moved during accel stall");
  a_run_lowers: assert property (@(posedge REF_CLK) disable iff (RST)
    run_lower && !stop_r && f_r != 16'h0000 |=> f_r < $past(f_r))
    else $error("frequency not lowered on running stall");
  a_reaccel_cmd: assert property (@(posedge REF_CLK) disable iff (RST)
    !stop_r && ph == DPS_CONST && !ov_hold && !run_lower &&
    f_r < F_CMD |=> f_r > $past(f_r))
    else $error("no reacceleration toward command");
  a_mode_off: assert property (@(posedge REF_CLK) disable iff (RST)
    ot_mode_r == 16'h0000 |-> !ot_expired)
    else $error("over-torque seen with detection off");
  a_stop_mode: assert property (@(posedge REF_CLK) disable iff (RST)
    ot_expired && ot_mode_r == 16'h0002 |=> stop_r)
    else $error("mode 2 did not stop drive");
  a_warn_follow: assert property (@(posedge REF_CLK) disable iff (RST)
    ot_warn_r |-> $past(ot_window && I_OUT > ot_lim))
    else $error("warning without sustained over-torque");
  a_mfo_warn: assert property (@(posedge REF_CLK) disable iff (RST)
    out_fn_r == FN_OVER_TORQUE |-> MFO == ot_warn_r)
    else $error("output does not follow warning");
  a_lvl_range: assert property (@(posedge REF_CLK) disable iff (RST)
    ot_lvl_r >= OT_LVL_MIN && ot_lvl_r <= OT_LVL_MAX)
    else $error("torque level out of range");
  a_time_range: assert property (@(posedge REF_CLK) disable iff (RST)
    ot_time_r >= OT_TIME_MIN && ot_time_r <= OT_TIME_MAX)
    else $error("torque time out of range");
  a_therm_range: assert property (@(posedge REF_CLK) disable iff (RST)
    therm_r <= THERM_MAX)
    else $error("thermal select out of range");
endmodule

// ==== dps_pkg.sv ====
// Package: register map, field widths, reset values and timing constants
package dps_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned TENTH_SEC_MS = 100;
  localparam int unsigned TENTH_CYC = (CLK_HZ / 1000) * TENTH_SEC_MS;

  localparam logic [7:0] OFF_OV_LVL = 8'h00;
  localparam logic [7:0] OFF_ACC_LVL = 8'h04;
  localparam logic [7:0] OFF_RUN_LVL = 8'h08;
  localparam logic [7:0] OFF_OT_MODE = 8'h0C;
  localparam logic [7:0] OFF_OT_LVL = 8'h10;
  localparam logic [7:0] OFF_OT_TIME = 8'h14;
  localparam logic [7:0] OFF_THERM = 8'h18;
  localparam logic [7:0] OFF_OUT_FN = 8'h1C;
  localparam logic [7:0] OFF_STATUS = 8'h20;
  localparam logic [7:0] OFF_IRQ_ST = 8'h24;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h28;

  localparam logic [15:0] RST_OV_LVL = 16'h0F3C;
  localparam logic [15:0] RST_ACC_LVL = 16'h00AA;
  localparam logic [15:0] RST_RUN_LVL = 16'h00AA;
  localparam logic [15:0] RST_OT_MODE = 16'h0000;
  localparam logic [15:0] RST_OT_LVL = 16'h0096;
  localparam logic [15:0] RST_OT_TIME = 16'h0001;
  localparam logic [15:0] RST_THERM = 16'h0002;
  localparam logic [15:0] RST_OUT_FN = 16'h0000;

  localparam logic [15:0] PCT_FULL = 16'h0064;
  localparam logic [15:0] OT_LVL_MIN = 16'h000A;
  localparam logic [15:0] OT_LVL_MAX = 16'h00C8;
  localparam logic [15:0] OT_TIME_MIN = 16'h0001;
  localparam logic [15:0] OT_TIME_MAX = 16'h0258;
  localparam logic [15:0] THERM_MAX = 16'h0002;
  localparam logic [15:0] OT_MODE_MAX = 16'h0004;
  localparam logic [15:0] FN_OVER_TORQUE = 16'h0004;
  localparam int IRQ_W = 4;
  localparam int IRQ_OT = 0;
  localparam int IRQ_OV = 1;
  localparam int IRQ_ACC = 2;
  localparam int IRQ_RUN = 3;

  typedef enum logic [1:0] {DPS_IDLE, DPS_ACCEL, DPS_CONST, DPS_DECEL}
    dps_phase_e;
endpackage

// ==== dps_scale.sv ====
// Scales a percent of rated current into a current code
`timescale 1ns/10ps
module dps_scale
  import dps_pkg::*;
#(
  parameter int CW = 16
) (
  input wire logic [15:0] PCT,
  input wire logic [CW-1:0] RATED,
  output logic [CW-1:0] LIMIT
);
  logic [CW+15:0] prod;
  always_comb begin
    prod = PCT * RATED;
    LIMIT = CW'(prod / {{CW{1'b0}}, PCT_FULL});
  end
endmodule

// ==== dps_timer.sv ====
// Over-torque persistence timer in tenths of a second
`timescale 1ns/10ps
module dps_timer
  import dps_pkg::*;
#(
  parameter int unsigned TICK_CYC = TENTH_CYC
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic ARM,
  input wire logic [15:0] LIMIT,
  output logic EXPIRED
);
  logic [31:0] cyc_r;
  logic [15:0] tenths_r;
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      cyc_r <= 32'h0000_0000;
      tenths_r <= 16'h0000;
    end else if (!ARM) begin
      cyc_r <= 32'h0000_0000;
      tenths_r <= 16'h0000;
    end else if (cyc_r == 32'(TICK_CYC - 1)) begin
      cyc_r <= 32'h0000_0000;
      if (tenths_r != 16'hFFFF)
        tenths_r <= tenths_r + 16'h0001;
    end else begin
      cyc_r <= cyc_r + 32'h0000_0001;
    end
  end
  // Longer than the setting: expires once the count passes the limit
  assign EXPIRED = ARM && (tenths_r > LIMIT) ||
    ARM && (tenths_r == LIMIT) && (cyc_r != 32'h0000_0000);
endmodule

// ==== dps_motor_model.sv ====
// Stand-in for the motor power stage: current and bus voltage sensing
`timescale 1ns/10ps
module dps_motor_model #(
  parameter int unsigned RATED = 1000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [15:0] i_load,
  input wire logic [15:0] v_set,
  output logic [15:0] i_out,
  output logic [15:0] i_rated,
  output logic [15:0] v_bus
);
  // ----------------------------------------
  // Sensing
  // ----------------------------------------
  // One clock of lag, as a sampled converter gives; the block must
  // not rely on seeing a load step in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      i_out <= 16'h0000;
      v_bus <= 16'h0000;
    end else begin
      i_out <= i_load;
      v_bus <= v_set;
    end
  end
  assign i_rated = 16'(RATED);
endmodule

// ==== test_drive_protection_supervisor.sv ====
// Self-checking bench for the drive protection supervisor
`timescale 1ns/10ps
module test_drive_protection_supervisor;
  import dps_pkg::*;
  // ----------------------------------------
  // Harness
  // ----------------------------------------
  logic clk, rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] i_out, i_rated, v_bus, f_cmd, f_step, f_out, i_load, v_set;
  logic [15:0] fa;
  logic [1:0] phase, tmode;
  logic th_trip, dr_trip, hold, lower, warn, stop, mfo, irq;
  int mismatches, n_compared;

  dps_motor_model i_dps_motor_model (.clk(clk), .rst(rst),
    .i_load(i_load), .v_set(v_set), .i_out(i_out), .i_rated(i_rated),
    .v_bus(v_bus));
  dps_supervisor #(.CW(16), .TICK_CYC(10)) i_dps_supervisor (
    .REF_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .I_OUT(i_out), .I_RATED(i_rated),
    .V_BUS(v_bus), .PHASE(phase), .F_CMD(f_cmd), .F_STEP(f_step),
    .THERMAL_OVERLOAD_TRIP(th_trip), .DRIVE_OVERLOAD_TRIP(dr_trip),
    .F_OUT(f_out), .FREQ_HOLD(hold), .FREQ_LOWER(lower),
    .OVER_TORQUE_WARNING(warn), .DRIVE_STOP(stop), .MFO(mfo),
    .THERMAL_MODE(tmode), .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic look();
    @(negedge clk);
  endtask

  // Read data stands through the access cycle and is taken at the edge
  // where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    look();
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0000, d});
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(tmode, 2'h2);
    rdchk(OFF_OV_LVL, 32'h0000_0F3C);
    rdchk(OFF_ACC_LVL, 32'h0000_00AA);
    rdchk(OFF_RUN_LVL, 32'h0000_00AA);
    rdchk(OFF_OT_MODE, 32'h0);
    rdchk(OFF_OT_LVL, 32'h0000_0096);
    rdchk(OFF_OT_TIME, 32'h0000_0001);
    rdchk(OFF_THERM, 32'h0000_0002);
    rdchk(8'h30, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_fields();
    logic [15:0] m;
    for (int k = 0; k < 5; k++) begin
      m = 16'(k);
      wr(OFF_OT_MODE, m);
      rdchk(OFF_OT_MODE, {16'h0000, m});
      if (k < 3) begin
        wr(OFF_THERM, m);
        chk(tmode, m);
      end
    end
    wr(OFF_OT_MODE, 16'h0005);
    rdchk(OFF_OT_MODE, 32'h0000_0004);
    wr(OFF_THERM, 16'h0003);
    rdchk(OFF_THERM, 32'h0000_0002);
    wr(OFF_OT_LVL, 16'h0005);
    rdchk(OFF_OT_LVL, 32'h0000_000A);
    wr(OFF_OT_LVL, 16'h012C);
    rdchk(OFF_OT_LVL, 32'h0000_00C8);
    wr(OFF_OT_TIME, 16'h0000);
    rdchk(OFF_OT_TIME, 32'h0000_0001);
    wr(OFF_OT_TIME, 16'h0259);
    rdchk(OFF_OT_TIME, 32'h0000_0258);
    wr(OFF_OT_LVL, 16'h0096);
    wr(OFF_OT_MODE, 16'h0000);
    $display("test fields done");
  endtask

  // Rated code 1000, so 170 percent is 1700 and must be exceeded
  task automatic t_accel();
    @(posedge clk);
    phase <= DPS_ACCEL;
    cyc(5);
    i_load <= 16'h06A5;
    cyc(3);
    look();
    chk(hold, 1'b1);
    fa = f_out;
    cyc(5);
    look();
    chk(f_out, fa);
    i_load <= 16'h06A4;
    cyc(3);
    look();
    chk(hold, 1'b0);
    wr(OFF_ACC_LVL, 16'h0000);
    i_load <= 16'h06A5;
    cyc(3);
    look();
    chk(hold, 1'b0);
    $display("test accel done");
  endtask

  task automatic t_run();
    @(posedge clk);
    phase <= DPS_CONST;
    f_cmd <= 16'h0064;
    i_load <= 16'h0000;
    cyc(120);
    look();
    chk(f_out, 32'h0000_0064);
    i_load <= 16'h06A5;
    cyc(3);
    look();
    chk(lower, 1'b1);
    chk(warn, 1'b0);
    fa = f_out;
    cyc(10);
    look();
    chk(f_out, fa - 10);
    i_load <= 16'h0000;
    cyc(3);
    look();
    fa = f_out;
    cyc(10);
    look();
    chk(f_out, fa + 10);
    wr(OFF_RUN_LVL, 16'h0000);
    i_load <= 16'h06A5;
    cyc(3);
    look();
    chk(lower, 1'b0);
    i_load <= 16'h0000;
    $display("test run done");
  endtask

  task automatic t_decel();
    @(posedge clk);
    phase <= DPS_DECEL;
    f_cmd <= 16'h0000;
    v_set <= 16'h0F3D;
    cyc(3);
    look();
    chk(hold, 1'b1);
    fa = f_out;
    cyc(5);
    look();
    chk(f_out, fa);
    v_set <= 16'h0F3C;
    cyc(3);
    look();
    fa = f_out;
    cyc(5);
    look();
    chk(f_out, fa - 5);
    wr(OFF_OV_LVL, 16'h0000);
    v_set <= 16'hFFFF;
    cyc(3);
    look();
    chk(hold, 1'b0);
    $display("test decel done");
  endtask

  // Level 1500, time 2 tenths of 10 cycles: expires after 21 cycles above, warning one clock later
  task automatic ot_on(input logic [15:0] m, input logic [1:0] ph,
                       input logic w, input logic s);
    wr(OFF_OT_MODE, m);
    phase <= ph;
    f_cmd <= 16'h0064;
    i_load <= 16'h05DD;
    for (int k = 0; k < 45 && warn !== 1'b1; k++) @(posedge clk);
    cyc(2);
    look();
    chk(warn, w);
    chk(stop, s);
  endtask

  task automatic ot_off();
    i_load <= 16'h0000;
    f_cmd <= 16'h0000;
    dr_trip <= 1'b0;
    th_trip <= 1'b0;
    cyc(3);
    look();
    chk(stop, 1'b0);
  endtask

  task automatic t_torque();
    wr(OFF_OT_TIME, 16'h0002);
    wr(OFF_OUT_FN, 16'h0004);
    wr(OFF_OT_MODE, 16'h0002);
    phase <= DPS_CONST;
    f_cmd <= 16'h0064;
    i_load <= 16'h05DD;
    cyc(12);
    i_load <= 16'h05DC;
    cyc(2);
    i_load <= 16'h05DD;
    cyc(14);
    look();
    chk(warn, 1'b0);
    ot_on(16'h0002, DPS_CONST, 1'b1, 1'b1);
    chk(mfo, 1'b1);
    chk(f_out, 32'h0);
    chk(irq, 1'b0);
    wr(OFF_IRQ_MASK, 16'h0001);
    chk(irq, 1'b1);
    i_load <= 16'h0000;
    cyc(3);
    look();
    chk(mfo, 1'b0);
    wr(OFF_IRQ_ST, 16'h0001);
    chk(irq, 1'b0);
    rdchk(OFF_IRQ_ST, 32'h0000_000E);
    ot_off();
    ot_on(16'h0003, DPS_CONST, 1'b0, 1'b0);
    ot_off();
    ot_on(16'h0004, DPS_ACCEL, 1'b1, 1'b1);
    ot_off();
    ot_on(16'h0001, DPS_CONST, 1'b1, 1'b0);
    dr_trip <= 1'b1;
    cyc(3);
    look();
    chk(stop, 1'b1);
    ot_off();
    ot_on(16'h0003, DPS_ACCEL, 1'b1, 1'b0);
    th_trip <= 1'b1;
    cyc(3);
    look();
    chk(stop, 1'b1);
    ot_off();
    $display("test torque done");
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, th_trip, dr_trip} = 5'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    {i_load, v_set, f_cmd} = {16'h0000, 16'h0000, 16'h03E8};
    f_step = 16'h0001;
    phase = DPS_IDLE;
    mismatches = 0;
    n_compared = 0;
    cyc(16);
    rst <= 1'b0;
    look();
    t_reset();
    t_fields();
    t_accel();
    t_run();
    t_decel();
    t_torque();
    give_verdict();
  end

  initial begin
    cyc(6000);
    mismatches++;
    give_verdict();
  end
endmodule
